// ---- common/ampc_pkg.sv ----
// constants, types and field layout of the audio mux panel control block
package ampc_pkg;

  // -----------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // -----------------------------------------------------------------
  localparam logic [7:0] AMPC_OFS_CTRL = 8'h00;   // behaviour, source, group, refs
  localparam logic [7:0] AMPC_OFS_STATUS = 8'h04; // presence and editor state
  localparam logic [7:0] AMPC_OFS_GAIN0 = 8'h08;  // gain of channel 0, then +4 each
  localparam logic [7:0] AMPC_OFS_ROUTE = 8'h18;  // 4x4 routing matrix
  localparam logic [7:0] AMPC_OFS_MISC = 8'h1c;   // invert and tie bits

  // -----------------------------------------------------------------
  // control word field positions
  // -----------------------------------------------------------------
  localparam int AMPC_CTRL_MUX = 0;       // [1:0] behaviour
  localparam int AMPC_CTRL_SRC = 2;       // [3:2] audio source
  localparam int AMPC_CTRL_GRP = 4;       // [5:4] group
  localparam int AMPC_CTRL_DREF = 6;      // 1 = -18 dBFS, 0 = -20 dBFS
  localparam int AMPC_CTRL_AREF = 7;      // 1 = +4 dBu, 0 = -10 dBu
  localparam int AMPC_CTRL_HEAD = 8;      // [10:8] headroom code
  localparam int AMPC_CTRL_STRIP = 11;    // strip embedded audio and EDH
  localparam int AMPC_GAIN_DEFAULT = 8;   // gain word: write 1 for unity
  localparam int AMPC_MISC_TIE = 4;       // [5:4] tie per pair

  // -----------------------------------------------------------------
  // reset values and limits
  // -----------------------------------------------------------------
  localparam logic [11:0] AMPC_CTRL_RST = 12'h000;
  localparam logic signed [7:0] AMPC_GAIN_UNITY = 8'sh00;
  localparam logic signed [7:0] AMPC_GAIN_MIN = -8'sd70;
  localparam logic signed [7:0] AMPC_GAIN_MAX = 8'sd12;
  localparam logic [15:0] AMPC_ROUTE_RST = 16'h8421; // input n to output n
  localparam logic [2:0] AMPC_HEAD_MAX = 3'h5;        // codes 0..5

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int AMPC_CLK_HZ = 10_000_000;
  localparam int AMPC_COMMIT_S = 15;     // seconds before commit
  localparam int AMPC_COMMIT_CYC = AMPC_COMMIT_S * AMPC_CLK_HZ;
  localparam int AMPC_BLINK_MS = 250;    // half period of edit blink
  localparam int AMPC_BLINK_CYC = AMPC_BLINK_MS * (AMPC_CLK_HZ / 1000);

  // -----------------------------------------------------------------
  // enumerations
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    AMPC_MUX_DEMUX = 2'h0, AMPC_MUX_REPLACE = 2'h1, AMPC_MUX_CASCADE = 2'h2
  } ampc_mux_t;
  typedef enum logic [1:0] {
    AMPC_SRC_AES = 2'h0, AMPC_SRC_ANLG_LO = 2'h1, AMPC_SRC_ANLG_PRO = 2'h2
  } ampc_src_t;
  typedef enum logic [1:0] {
    AMPC_PRES_NONE = 2'h0, AMPC_PRES_525 = 2'h1, AMPC_PRES_625 = 2'h2
  } ampc_pres_t;
  typedef enum logic [1:0] {
    AMPC_AES_NONE = 2'h0, AMPC_AES_AUDIO = 2'h1, AMPC_AES_DATA = 2'h2, AMPC_AES_OUT = 2'h3
  } ampc_aes_t;
  typedef enum logic [1:0] {
    AMPC_LED_OFF = 2'h0, AMPC_LED_GREEN = 2'h1, AMPC_LED_ORANGE = 2'h2, AMPC_LED_RED = 2'h3
  } ampc_led_t;
  typedef enum logic [2:0] {
    AMPC_ED_IDLE = 3'h0, AMPC_ED_MUX = 3'h1, AMPC_ED_SRC = 3'h2,
    AMPC_ED_GRP = 3'h3, AMPC_ED_GAIN12 = 3'h4, AMPC_ED_GAIN34 = 3'h5
  } ampc_ed_t;

  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic above_m20;      // above -20 VU
    logic above_0;        // above 0 VU
    logic [3:0] peak_db;  // peak dB below clipping, saturating
  } ampc_meter_t;

  typedef struct packed {
    logic in_green;
    logic [2:0] mux_green;   // demux, replace, cascade
    logic [2:0] src_green;   // aes, analog -10, analog +4
    logic [1:0] grp_num;     // group shown
    ampc_led_t grp_led;
    ampc_led_t [1:0] vu_led; // per channel pair
    ampc_led_t [1:0] gain_led;
  } ampc_panel_t;

  typedef struct packed {
    logic [1:0] mux;
    logic [1:0] src;
    logic [1:0] grp;
    logic [3:0][7:0] gain;
  } ampc_nv_t;

endpackage

// ---- dv/ampc_btn_model.sv ----
// front panel button model: a press request becomes a held button
`timescale 1ns/1ps
`default_nettype none
module ampc_btn_model (
  // clock
  input wire logic clk_i,
  // press requests, bit 0 mode, 1 right, 2 left
  input wire logic [2:0] press_i,
  // button pins, high while pressed
  output logic [2:0] btn_o
);
  logic [2:0][2:0] hold_r = '0; // cycles left down, per button
  // hold each press long enough for the two stage sync to see one edge
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (press_i[i]) hold_r[i] <= 3'h6;
      else if (hold_r[i] != 3'h0) hold_r[i] <= hold_r[i] - 3'h1;
    end
  end
  // pin is down while the hold count runs
  always_comb for (int i = 0; i < 3; i++) btn_o[i] = (hold_r[i] != 3'h0);
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench of the panel control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ampc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, sdi_v = 0, sdi_625 = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic [2:0] press = 3'h0;
  logic [3:0] gp = 4'h1; // group presence pins
  logic [1:0] a12 = 2'h1, a34 = 2'h3; // audio port status pins
  int nv_pulses = 0; // store pulses seen after a mid-run reset
  wire logic [2:0] btn;
  ampc_meter_t [3:0] meter = {6'h3f, 6'h30, 6'h3f, 6'h3f}; // pair 1 sits at clipping
  logic ack, nvw, act, strip, mref;
  ampc_nv_t nvd;
  ampc_panel_t pan;
  ampc_mux_t mux;
  logic [1:0] grp;
  logic [3:0][7:0] gain;
  logic [3:0] inv;
  int failures = 0, total_checks = 0;
  // rows: control word beside the one-hot mux and source lamps it should give
  logic [11:0] row_ctl [4] = '{12'h040, 12'h045, 12'h00a, 12'h8ba};
  logic row_ref [4] = '{1'b1, 1'b0, 1'b0, 1'b1}; // meter reference each row should pick
  logic [2:0] row_hot [4] = '{3'h1, 3'h2, 3'h4, 3'h4};
  ampc_btn_model pnl (.clk_i(clk_i), .press_i(press), .btn_o(btn));
  ampc_ctrl #(.COMMIT_CYC(200), .BLINK_CYC(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_ack_o(ack),
    .wb_dat_o(dat_o), .btn_mode_i(btn[0]), .btn_right_i(btn[1]), .btn_left_i(btn[2]),
    .sdi_valid_i(sdi_v), .sdi_625_i(sdi_625), .grp_present_i(gp), .aes12_stat_i(a12),
    .aes34_stat_i(a34), .meter_i(meter), .nv_restore_i(1'b0), .nv_rdata_i('0), .nv_write_o(nvw),
    .nv_wdata_o(nvd), .panel_o(pan), .mux_o(mux), .src_o(), .src_active_o(act), .grp_o(grp),
    .strip_o(strip), .dref_18_o(), .aref_4_o(), .meter_ref_pro_o(mref), .gain_o(gain), .route_o(),
    .invert_o(inv));
  // 100 ns clock
  initial forever #50 clk_i = ~clk_i;
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // classic wishbone cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask
  // one button press, then let the panel settle
  task automatic push(input int b);
    press[b] <= 1'b1;
    @(posedge clk_i);
    press[b] <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    failures++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    chk(pan, '0);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, AMPC_OFS_ROUTE, 32'h0); chk(rdat, 32'h8421);
    for (int i = 0; i < 4; i++) begin
      wb(1, AMPC_OFS_CTRL, {20'h0, row_ctl[i]});
      repeat (3) @(posedge clk_i);
      chk(pan.mux_green, row_hot[i]);
      chk(pan.src_green, row_hot[i]);
      chk(act, row_ctl[i][1:0] != 2'h0);
      chk(grp, row_ctl[i][5:4]);
      chk(strip, row_ctl[i][11]);
      chk(mref, row_ref[i]);
    end
    $display("test done: control rows");
    // mux code 3 must be refused, cascade kept
    wb(1, AMPC_OFS_CTRL, 32'h83b); chk(mux, AMPC_MUX_CASCADE);
    sdi_v <= 1'b1; sdi_625 <= 1'b1;
    repeat (5) @(posedge clk_i);
    wb(0, AMPC_OFS_STATUS, 32'h0); chk(rdat[5:0], 6'h36);
    chk(pan.in_green, 1'b1);
    chk(pan.grp_led, AMPC_LED_RED);
    chk(pan.vu_led[0], AMPC_LED_ORANGE);
    chk(pan.vu_led[1], AMPC_LED_RED);
    gp <= 4'h8;
    a12 <= 2'h2;
    a34 <= 2'h0;
    repeat (4) @(posedge clk_i);
    chk(pan.grp_led, AMPC_LED_GREEN);
    wb(0, AMPC_OFS_STATUS, 32'h0); chk(rdat[6:0], 7'h4a);
    // headroom code 2: a peak within 4 dB of clipping wins over orange
    wb(1, AMPC_OFS_CTRL, 32'h23a);
    meter <= {6'h0f, 6'h2f, 6'h3f, 6'h34};
    repeat (2) @(posedge clk_i);
    chk(pan.vu_led[0], AMPC_LED_RED);
    chk(pan.vu_led[1], AMPC_LED_GREEN);
    meter <= {4{6'h0f}};
    repeat (2) @(posedge clk_i);
    chk(pan.vu_led[0], AMPC_LED_OFF);
    chk(pan.vu_led[1], AMPC_LED_OFF);
    wb(0, 8'h40, 32'h0); chk(rdat, 32'h0);
    $display("test done: status and lamps");
    wb(1, AMPC_OFS_GAIN0, 32'h80); chk(gain[0], 8'hba);
    wb(1, AMPC_OFS_GAIN0, 32'h7f); chk(gain[0], 8'h0c);
    repeat (3) @(posedge clk_i);
    chk(pan.gain_led[0], AMPC_LED_RED);
    wb(1, AMPC_OFS_GAIN0, 32'h100); chk(gain[0], 8'h00);
    wb(1, AMPC_OFS_MISC, 32'h11); chk(inv, 4'h1);
    wb(1, AMPC_OFS_GAIN0, 32'h05); chk(gain[1], 8'h05);
    // pair far apart, then a tied step of -82 dB must clamp, not wrap
    wb(1, AMPC_OFS_MISC, 32'h01);
    wb(1, AMPC_OFS_GAIN0 + 8'h04, 32'hba);
    wb(1, AMPC_OFS_GAIN0, 32'h0c);
    wb(1, AMPC_OFS_MISC, 32'h11);
    wb(1, AMPC_OFS_GAIN0, 32'hba); chk(gain[1], 8'hba);
    $display("test done: mixer");
    wb(1, AMPC_OFS_CTRL, 32'h0);
    push(0);
    push(1);
    chk(mux, AMPC_MUX_REPLACE);
    for (int k = 0; k < 300 && nvw !== 1'b1; k++) @(posedge clk_i);
    chk(nvw, 1'b1);
    chk(nvd.mux, 2'h1);
    $display("test done: panel edit");
    // reset while an edit is pending must drop it, as a power loss would
    push(2);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, AMPC_OFS_STATUS, 32'h0); chk(rdat[10:7], 4'h0);
    for (int k = 0; k < 250; k++) begin
      @(posedge clk_i);
      if (nvw === 1'b1) nv_pulses++;
    end
    chk(nv_pulses, 0);
    $display("test done: reset drops edit");
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ---- rtl/ampc_ctrl.sv ----
// control, status, panel and mixer settings of the audio mux
//
// The Wishbone slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ampc_ctrl #(
  parameter int COMMIT_CYC = ampc_pkg::AMPC_COMMIT_CYC, // commit delay
  parameter int BLINK_CYC = ampc_pkg::AMPC_BLINK_CYC    // blink half period
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // front panel buttons (pins)
  input wire logic btn_mode_i,
  input wire logic btn_right_i,
  input wire logic btn_left_i,
  // video and audio port status (pins)
  input wire logic sdi_valid_i,
  input wire logic sdi_625_i,
  input wire logic [3:0] grp_present_i,
  input wire logic [1:0] aes12_stat_i,
  input wire logic [1:0] aes34_stat_i,
  // meters from the audio path (same clock)
  input wire ampc_pkg::ampc_meter_t [3:0] meter_i,
  // nonvolatile store (same clock)
  input wire logic nv_restore_i,
  input wire ampc_pkg::ampc_nv_t nv_rdata_i,
  output logic nv_write_o,
  output ampc_pkg::ampc_nv_t nv_wdata_o,
  // panel indicators
  output ampc_pkg::ampc_panel_t panel_o,
  // settings to the audio path
  output ampc_pkg::ampc_mux_t mux_o,
  output ampc_pkg::ampc_src_t src_o,
  output logic src_active_o,
  output logic [1:0] grp_o,
  output logic strip_o,
  output logic dref_18_o,
  output logic aref_4_o,
  output logic meter_ref_pro_o,
  output logic [3:0][7:0] gain_o,
  output logic [3:0][3:0] route_o,
  output logic [3:0] invert_o
);
  import ampc_pkg::*;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  localparam int NSYNC = 14;
  logic [NSYNC-1:0] raw; // pins gathered
  logic [NSYNC-1:0] s1_r; // first stage, read by s2_r only
  logic [NSYNC-1:0] s2_r; // safe copies
  logic [2:0] btn_q_r; // previous button levels
  assign raw = {btn_mode_i, btn_right_i, btn_left_i, sdi_valid_i, sdi_625_i,
                grp_present_i, aes12_stat_i, aes34_stat_i, 1'b0};

  // two flops per pin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
    end
  end

  logic b_mode, b_right, b_left, in_valid, in_625;
  logic [3:0] grp_pres;
  logic [1:0] aes12, aes34;
  assign {b_mode, b_right, b_left, in_valid, in_625} = s2_r[13:9];
  assign grp_pres = s2_r[8:5];
  assign aes12 = s2_r[4:3];
  assign aes34 = s2_r[2:1];

  // rising edges only; buttons are assumed debounced outside
  always_ff @(posedge clk_i) begin
    if (rst_i) btn_q_r <= '0;
    else btn_q_r <= {b_mode, b_right, b_left};
  end
  logic mode_p, right_p, left_p;
  assign mode_p = b_mode & ~btn_q_r[2];
  assign right_p = b_right & ~btn_q_r[1];
  assign left_p = b_left & ~btn_q_r[0];

  // -----------------------------------------------------------------
  // wishbone strobes
  // -----------------------------------------------------------------
  logic ack_r; // answer one cycle after request
  logic bus_req, bus_wr;
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign bus_wr = bus_req & wb_we_i;
  logic wr_ctrl, wr_route, wr_misc;
  assign wr_ctrl = bus_wr && wb_adr_i == AMPC_OFS_CTRL;
  assign wr_route = bus_wr && wb_adr_i == AMPC_OFS_ROUTE;
  assign wr_misc = bus_wr && wb_adr_i == AMPC_OFS_MISC && wb_sel_i[0];

  // -----------------------------------------------------------------
  // editor state machine
  // -----------------------------------------------------------------
  ampc_ed_t ed_r; // current panel section
  always_ff @(posedge clk_i) begin
    if (rst_i) ed_r <= AMPC_ED_IDLE;
    else if (mode_p) begin
      case (ed_r)
        AMPC_ED_IDLE: ed_r <= AMPC_ED_MUX;
        AMPC_ED_MUX: ed_r <= AMPC_ED_SRC;
        AMPC_ED_SRC: ed_r <= AMPC_ED_GRP;
        AMPC_ED_GRP: ed_r <= AMPC_ED_GAIN12;
        AMPC_ED_GAIN12: ed_r <= AMPC_ED_GAIN34;
        AMPC_ED_GAIN34: ed_r <= AMPC_ED_IDLE; // leaves edit mode
        default: ed_r <= AMPC_ED_IDLE;
      endcase
    end
  end

  // arrow press acts only inside a section
  logic arrow_p, edit_p;
  assign arrow_p = right_p | left_p;
  assign edit_p = arrow_p && ed_r != AMPC_ED_IDLE;

  // step a choice value up or down without wrapping
  function automatic logic [1:0] step2(input logic [1:0] v, input logic [1:0] top, input logic up);
    if (up) return (v < top) ? v + 2'h1 : v;
    return (v != 2'h0) ? v - 2'h1 : v;
  endfunction

  // step a gain by one dB, clamped to the legal range
  function automatic logic [7:0] gstep(input logic [7:0] g, input logic up);
    if (up) return ($signed(g) < AMPC_GAIN_MAX) ? g + 8'h01 : g;
    return ($signed(g) > AMPC_GAIN_MIN) ? g - 8'h01 : g;
  endfunction

  // clamp a written gain into range
  function automatic logic [7:0] gclamp(input logic [7:0] g);
    if ($signed(g) > AMPC_GAIN_MAX) return AMPC_GAIN_MAX;
    if ($signed(g) < AMPC_GAIN_MIN) return AMPC_GAIN_MIN;
    return g;
  endfunction

  // -----------------------------------------------------------------
  // configuration register
  // -----------------------------------------------------------------
  logic [1:0] mux_r, src_r, grp_r;
  logic dref_r, aref_r, strip_r;
  logic [2:0] head_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {strip_r, head_r, aref_r, dref_r, grp_r, src_r, mux_r} <= AMPC_CTRL_RST;
    end else if (nv_restore_i) begin
      mux_r <= nv_rdata_i.mux;
      src_r <= nv_rdata_i.src;
      grp_r <= nv_rdata_i.grp;
    end else if (edit_p) begin
      case (ed_r)
        AMPC_ED_MUX: mux_r <= step2(mux_r, AMPC_MUX_CASCADE, right_p);
        AMPC_ED_SRC: src_r <= step2(src_r, AMPC_SRC_ANLG_PRO, right_p);
        AMPC_ED_GRP: grp_r <= step2(grp_r, 2'h3, right_p);
        default: ;
      endcase
    end else if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        // illegal behaviour and source codes are ignored
        if (wb_dat_i[AMPC_CTRL_MUX +: 2] != 2'h3) mux_r <= wb_dat_i[AMPC_CTRL_MUX +: 2];
        if (wb_dat_i[AMPC_CTRL_SRC +: 2] != 2'h3) src_r <= wb_dat_i[AMPC_CTRL_SRC +: 2];
        grp_r <= wb_dat_i[AMPC_CTRL_GRP +: 2];
        dref_r <= wb_dat_i[AMPC_CTRL_DREF];
        aref_r <= wb_dat_i[AMPC_CTRL_AREF];
      end
      if (wb_sel_i[1]) begin
        if (wb_dat_i[AMPC_CTRL_HEAD +: 3] <= AMPC_HEAD_MAX) head_r <= wb_dat_i[AMPC_CTRL_HEAD +: 3];
        strip_r <= wb_dat_i[AMPC_CTRL_STRIP];
      end
    end
  end

  // -----------------------------------------------------------------
  // gains, routing, invert, tie
  // -----------------------------------------------------------------
  logic [3:0][7:0] gain_r;
  logic [3:0][3:0] route_r;
  logic [3:0] inv_r;
  logic [1:0] tie_r;

  genvar gc;
  generate
    for (gc = 0; gc < 4; gc++) begin : g_ch
      localparam int MATE = gc ^ 1; // other channel of the pair
      localparam int PAIR = gc / 2;
      logic my_wr, mate_wr, pan_hit;
      logic [7:0] wval, mval;
      logic signed [9:0] msum; // this channel's gain after the mate's move, before clamping
      assign my_wr = bus_wr && wb_adr_i == AMPC_OFS_GAIN0 + 8'(4 * gc);
      assign mate_wr = bus_wr && wb_adr_i == AMPC_OFS_GAIN0 + 8'(4 * MATE) && tie_r[PAIR];
      assign wval = wb_dat_i[AMPC_GAIN_DEFAULT] ? AMPC_GAIN_UNITY : gclamp(wb_dat_i[7:0]);
      assign pan_hit = edit_p && ed_r == (PAIR == 0 ? AMPC_ED_GAIN12 : AMPC_ED_GAIN34);
      // tied change on the mate moves this channel by the same amount;
      // summed two bits wider so a large step cannot wrap before clamping
      assign msum = $signed({{2{gain_r[gc][7]}}, gain_r[gc]}) + $signed({{2{wval[7]}}, wval})
                    - $signed({{2{gain_r[MATE][7]}}, gain_r[MATE]});
      assign mval = (msum > AMPC_GAIN_MAX) ? AMPC_GAIN_MAX
                    : (msum < AMPC_GAIN_MIN) ? AMPC_GAIN_MIN : msum[7:0];
      always_ff @(posedge clk_i) begin
        if (rst_i) gain_r[gc] <= AMPC_GAIN_UNITY;
        else if (nv_restore_i) gain_r[gc] <= nv_rdata_i.gain[gc];
        else if (pan_hit) gain_r[gc] <= gstep(gain_r[gc], right_p);
        else if (my_wr && (wb_sel_i[0] || wb_sel_i[1])) gain_r[gc] <= wval;
        else if (mate_wr && (wb_sel_i[0] || wb_sel_i[1])) gain_r[gc] <= mval;
      end
    end
  endgenerate

  // routing matrix: nibble n holds outputs fed by input n
  always_ff @(posedge clk_i) begin
    if (rst_i) route_r <= AMPC_ROUTE_RST;
    else if (wr_route && (wb_sel_i[0] || wb_sel_i[1])) route_r <= wb_dat_i[15:0];
  end

  // polarity and tie switches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inv_r <= '0;
      tie_r <= '0;
    end else if (wr_misc) begin
      inv_r <= wb_dat_i[3:0];
      tie_r <= wb_dat_i[AMPC_MISC_TIE +: 2];
    end
  end

  // -----------------------------------------------------------------
  // commit timer and blink
  // -----------------------------------------------------------------
  logic pend_r; // edit waiting for commit
  logic [2:0] pend_sec_r; // which indicator blinks
  logic [31:0] cnt_r; // cycles since last edit
  logic commit;
  assign commit = pend_r && cnt_r == 32'(COMMIT_CYC - 1);

  // each edit restarts the wait; reset discards an uncommitted edit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      pend_sec_r <= AMPC_ED_IDLE;
      cnt_r <= '0;
    end else if (edit_p) begin
      pend_r <= 1'b1;
      pend_sec_r <= ed_r;
      cnt_r <= '0;
    end else if (commit) begin
      pend_r <= 1'b0;
      cnt_r <= '0;
    end else if (pend_r) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // store pulse and snapshot of the panel-editable values
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_write_o <= 1'b0;
      nv_wdata_o <= '0;
    end else begin
      nv_write_o <= commit;
      if (commit) nv_wdata_o <= '{mux: mux_r, src: src_r, grp: grp_r, gain: gain_r};
    end
  end

  // blink phase divider, free running
  logic [31:0] bl_cnt_r;
  logic blink_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bl_cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (bl_cnt_r == 32'(BLINK_CYC - 1)) begin
      bl_cnt_r <= '0;
      blink_r <= ~blink_r;
    end else begin
      bl_cnt_r <= bl_cnt_r + 32'h1;
    end
  end
  logic dark; // blanking phase of the edited indicator
  assign dark = pend_r & blink_r;

  // -----------------------------------------------------------------
  // level indicators
  // -----------------------------------------------------------------
  logic [3:0] over_head; // peak within chosen headroom
  generate
    for (gc = 0; gc < 4; gc++) begin : g_peak
      assign over_head[gc] = {1'b0, meter_i[gc].peak_db} <= {1'b0, head_r, 1'b0};
    end
  endgenerate

  // color with red over orange over green
  function automatic ampc_led_t vu_color(input logic red, input logic o, input logic g);
    if (red) return AMPC_LED_RED;
    if (o) return AMPC_LED_ORANGE;
    if (g) return AMPC_LED_GREEN;
    return AMPC_LED_OFF;
  endfunction

  ampc_led_t [1:0] vu_c, gain_c;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_pair
      assign vu_c[gc] = vu_color(|over_head[2*gc +: 2],
                                 meter_i[2*gc].above_0 | meter_i[2*gc+1].above_0,
                                 meter_i[2*gc].above_m20 | meter_i[2*gc+1].above_m20);
      assign gain_c[gc] = (gain_r[2*gc] != AMPC_GAIN_UNITY || gain_r[2*gc+1] != AMPC_GAIN_UNITY)
                          ? AMPC_LED_RED : AMPC_LED_OFF;
    end
  endgenerate

  // -----------------------------------------------------------------
  // panel register
  // -----------------------------------------------------------------
  logic embed;
  assign embed = mux_r != AMPC_MUX_DEMUX;
  always_ff @(posedge clk_i) begin
    if (rst_i) panel_o <= '0;
    else begin
      panel_o.in_green <= in_valid;
      panel_o.mux_green <= (dark && pend_sec_r == AMPC_ED_MUX) ? 3'h0 : 3'(3'h1 << mux_r);
      panel_o.src_green <= (dark && pend_sec_r == AMPC_ED_SRC) ? 3'h0 : 3'(3'h1 << src_r);
      panel_o.grp_num <= grp_r;
      panel_o.grp_led <= (dark && pend_sec_r == AMPC_ED_GRP) ? AMPC_LED_OFF
                         : grp_pres[grp_r] ? AMPC_LED_GREEN : AMPC_LED_RED;
      panel_o.vu_led <= vu_c;
      panel_o.gain_led[0] <= (dark && pend_sec_r == AMPC_ED_GAIN12) ? AMPC_LED_OFF : gain_c[0];
      panel_o.gain_led[1] <= (dark && pend_sec_r == AMPC_ED_GAIN34) ? AMPC_LED_OFF : gain_c[1];
    end
  end

  // -----------------------------------------------------------------
  // settings to the audio path
  // -----------------------------------------------------------------
  assign mux_o = ampc_mux_t'(mux_r);
  assign src_o = ampc_src_t'(src_r);
  assign src_active_o = embed;
  assign grp_o = grp_r;
  assign strip_o = strip_r;
  assign dref_18_o = dref_r;
  assign aref_4_o = aref_r;
  // meter reference: analog level when analog is the source and the mux is not in demux, else digital
  assign meter_ref_pro_o = (embed && src_r != AMPC_SRC_AES) ? aref_r : dref_r;
  assign gain_o = gain_r;
  assign route_o = route_r;
  assign invert_o = inv_r;

  // -----------------------------------------------------------------
  // read mux and ack
  // -----------------------------------------------------------------
  ampc_pres_t pres;
  assign pres = !in_valid ? AMPC_PRES_NONE : in_625 ? AMPC_PRES_625 : AMPC_PRES_525;
  logic [31:0] rd_nxt;
  always_comb begin
    rd_nxt = 32'h0; // unmapped reads give zero
    case (wb_adr_i)
      AMPC_OFS_CTRL: rd_nxt = {20'h0, strip_r, head_r, aref_r, dref_r, grp_r, src_r, mux_r};
      AMPC_OFS_STATUS: rd_nxt = {16'h0, 4'h0, embed, pend_r, ed_r, grp_pres[grp_r],
                                 aes34, aes12, pres};
      AMPC_OFS_ROUTE: rd_nxt = {16'h0, route_r};
      AMPC_OFS_MISC: rd_nxt = {26'h0, tie_r, inv_r};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (wb_adr_i == AMPC_OFS_GAIN0 + 8'(4 * i)) rd_nxt = {24'h0, gain_r[i]};
        end
      end
    endcase
  end

  // single cycle answer, dropped in the following cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i) wb_dat_o <= rd_nxt;
    end
  end
  assign wb_ack_o = ack_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence first_press_s;
    mode_p && ed_r == AMPC_ED_IDLE;
  endsequence

  in_led_a: assert property (panel_o.in_green == $past(in_valid) || $past(rst_i))
    else $error("input led does not follow input valid");
  mux_led_a: assert property (!dark |=> $onehot0(panel_o.mux_green))
    else $error("more than one mux led lit");
  grp_led_a: assert property (!$past(dark) && !$past(rst_i) |-> panel_o.grp_led ==
    ($past(grp_pres[grp_r]) ? AMPC_LED_GREEN : AMPC_LED_RED)) else $error("group led color wrong");
  vu_red_a: assert property (over_head[0] |=> panel_o.vu_led[0] == AMPC_LED_RED)
    else $error("headroom not shown red");
  gain_led_a: assert property (gain_r[0] != AMPC_GAIN_UNITY && !dark |=> panel_o.gain_led[0] == AMPC_LED_RED)
    else $error("gain led not red off unity");
  edit_enter_a: assert property (first_press_s |=> ed_r == AMPC_ED_MUX)
    else $error("mode press did not enter editing");
  commit_time_a: assert property (nv_write_o |-> $past(pend_r) && $past(cnt_r) == 32'(COMMIT_CYC - 1))
    else $error("commit before timeout");
  gain_range_a: assert property ($signed(gain_r[1]) >= AMPC_GAIN_MIN && $signed(gain_r[1]) <= AMPC_GAIN_MAX)
    else $error("gain out of range");
  tie_pair_a: assert property (g_ch[0].my_wr && tie_r[0] && wb_sel_i[0] && !edit_p && !nv_restore_i
    |=> gain_r[1] != $past(gain_r[1]) || $past(gain_r[0]) == $past(g_ch[0].wval)
        || $past(gain_r[1]) == AMPC_GAIN_MIN || $past(gain_r[1]) == AMPC_GAIN_MAX)
    else $error("tie did not move mate");
  bus_ack_a: assert property (bus_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not single cycle");

endmodule
`default_nettype wire
